// ### rtl/vmc_accum.v
`timescale 1ns/1ns
`include "vmc_consts.vh"
// one energy or demand accumulator with gated add and clear
module vmc_accum #(
    parameter WIDTH = 32
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst_b,
    // control
    input  wire             enable,
    input  wire             clear,
    input  wire [WIDTH-1:0] increment,
    // value
    output reg  [WIDTH-1:0] total
);
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            total <= {WIDTH{1'b0}};
        end else if (clear) begin
            total <= {WIDTH{1'b0}};
        end else if (enable) begin
            total <= total + increment;
        end
    end
endmodule

// ### rtl/vmc_consts.vh
`ifndef VMC_CONSTS_VH
`define VMC_CONSTS_VH
// register word addresses
`define VMC_ADDR_CTRL      4'h0
`define VMC_ADDR_CMD       4'h1
`define VMC_ADDR_TIMEOUT   4'h2
`define VMC_ADDR_PULSE     4'h3
`define VMC_ADDR_STATUS    4'h4
`define VMC_ADDR_REMAIN    4'h5
`define VMC_ADDR_PASSWORD  4'h6
`define VMC_ADDR_COMM      4'h7
`define VMC_ADDR_PARAM     4'h8
`define VMC_ADDR_ACC_SEL   4'h9
`define VMC_ADDR_ACC_DATA  4'hA
// ctrl field positions
`define VMC_CTRL_SCALE     0
`define VMC_CTRL_LOSS      1
// cmd field positions
`define VMC_CMD_ENTER      0
`define VMC_CMD_CLOSE      1
`define VMC_CMD_CLR_REFUSED 3
// status field positions
`define VMC_STAT_VERIFY    0
`define VMC_STAT_LOCKED    1
`define VMC_STAT_SECURE    2
`define VMC_STAT_REFUSED   3
`define VMC_STAT_SCREEN    4
// reset values
`define VMC_TIMEOUT_S_RST  32'h0000_0708
`define VMC_PULSE_RST      32'h0000_03E8
`define VMC_CTRL_RST       2'h0
// timing
`define VMC_CLK_HZ         100000000
`define VMC_TICK_S         1
`define VMC_SCREEN_S       5
`define VMC_NUM_SCREENS    4
`endif

// ### rtl/vmc_top.v
// What this block does
// - front-panel verify button enters verification state
// - locked meter refuses ctrl, timeout, pulse and param writes normally
// - locked meter ignores software entry requests
// - secure meter needs password for software entry
// - inactivity timeout leaves verification, default 1800s
// - remaining seconds readable for status bar
// - timeout always returns to regular operation
// - timeout in seconds, locked writes need verification
// - host close request exits verification
// - separate accumulators add only in verification
// - display cycles four verification screens
// - demand accumulators cleared by demand reset switch
// - two led/ir pairs pulse at configurable rate
// - scaling enable, resets disabled
// - loss-mode enable gates loss compensation
// - verification accumulators cleared on every exit
// - regular accumulators pause during verification
// - any exit lands in regular operation
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ns
`include "vmc_consts.vh"
module vmc_top #(
    parameter TICK_CYCLES   = `VMC_CLK_HZ * `VMC_TICK_S,
    parameter SCREEN_TICKS  = `VMC_SCREEN_S,
    // password value is arbitrary; products set their own
    parameter PASSWORD      = 32'h1234_5678,
    parameter EW            = 32
) (
    // clock and reset
    input  wire          clk,
    input  wire          rst_b,
    // front panel
    input  wire          verify_button,
    input  wire          any_button,
    input  wire          demand_reset_switch,
    input  wire          alt_button,
    // straps
    input  wire          hw_locked,
    input  wire          security_enabled,
    // metering increments per cycle
    input  wire [EW-1:0] real_del_inc,
    input  wire [EW-1:0] real_rec_inc,
    input  wire [EW-1:0] react_inc,
    input  wire [EW-1:0] appar_inc,
    input  wire [EW-1:0] demand_del_inc,
    input  wire [EW-1:0] demand_rec_inc,
    input  wire          energy_pulse_event,
    // register port
    input  wire [3:0]    addr,
    input  wire [31:0]   wdata,
    input  wire          wr,
    input  wire          rd,
    output reg  [31:0]   rdata,
    // mode outputs
    output reg           verify_active,
    output reg           regular_operation_state,
    output reg           secondary_display_state,
    output reg           billing_enable,
    output reg           scaling_enable,
    output reg           loss_enable,
    output reg  [1:0]    screen_sel,
    output reg  [31:0]   remaining_s,
    output reg  [1:0]    led_pulse,
    output reg  [1:0]    ir_pulse
);
    localparam ST_REG = 2'h0;
    localparam ST_ALT = 2'h1;
    localparam ST_VER = 2'h2;

    // ****************************************
    // reset release
    // ****************************************
    reg rst_s1;
    reg rst_s2;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end
    // logic leaves reset only on a clock edge, never mid-cycle
    wire rst_n = rst_s2;

    // ****************************************
    // registers and decode
    // ****************************************
    reg  [1:0]  state;
    reg  [1:0]  next_state;
    reg  [31:0] timeout_s;
    reg  [31:0] pulse_div;
    reg  [31:0] password_in;
    reg  [31:0] comm_param;
    reg  [31:0] gen_param;
    reg  [2:0]  acc_sel;
    reg         refused;
    reg  [31:0] countdown;
    reg  [31:0] tick_cnt;
    reg  [31:0] scr_cnt;
    reg  [31:0] pulse_cnt;
    reg         pulse_phase;
    wire        in_ver = (state == ST_VER);
    wire        tick = (tick_cnt == TICK_CYCLES - 1);
    wire        w_ctrl = wr && addr == `VMC_ADDR_CTRL;
    wire        w_cmd = wr && addr == `VMC_ADDR_CMD;
    // locked meter takes general settings only in verification
    wire        gen_ok = !hw_locked || in_ver;
    wire        sw_enter_req = w_cmd && wdata[`VMC_CMD_ENTER];
    wire        pw_ok = !security_enabled || password_in == PASSWORD;
    wire        sw_enter = sw_enter_req && !hw_locked && pw_ok;
    wire        sw_close = w_cmd && wdata[`VMC_CMD_CLOSE] && in_ver;
    // a press in the expiry cycle reloads the count instead of letting it lapse
    wire        expired = in_ver && tick && countdown <= 32'h0000_0001 &&
                    !any_button && !verify_button;
    wire        exit_ver = sw_close || expired;
    wire        gen_refuse = wr && !gen_ok &&
                    (addr == `VMC_ADDR_CTRL || addr == `VMC_ADDR_TIMEOUT ||
                     addr == `VMC_ADDR_PULSE || addr == `VMC_ADDR_PARAM);

    // ****************************************
    // mode sequencer
    // ****************************************
    always @* begin
        next_state = state;
        case (state)
            ST_REG: begin
                if (verify_button || sw_enter) next_state = ST_VER;
                else if (alt_button) next_state = ST_ALT;
            end
            ST_ALT: begin
                if (verify_button || sw_enter) next_state = ST_VER;
                else if (alt_button) next_state = ST_REG;
            end
            ST_VER: begin
                if (exit_ver) next_state = ST_REG;
            end
            default: next_state = ST_REG;
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state       <= ST_REG;
            timeout_s   <= `VMC_TIMEOUT_S_RST;
            pulse_div   <= `VMC_PULSE_RST;
            password_in <= 32'h0000_0000;
            comm_param  <= 32'h0000_0000;
            gen_param   <= 32'h0000_0000;
            acc_sel     <= 3'h0;
            refused     <= 1'b0;
            scaling_enable <= 1'b0;
            loss_enable <= 1'b0;
        end else begin
            state <= next_state;
            if (w_ctrl && gen_ok) begin
                scaling_enable <= wdata[`VMC_CTRL_SCALE];
                loss_enable    <= wdata[`VMC_CTRL_LOSS];
            end
            if (wr && addr == `VMC_ADDR_TIMEOUT && gen_ok && wdata != 32'h0)
                timeout_s <= wdata;
            if (wr && addr == `VMC_ADDR_PULSE && gen_ok && wdata != 32'h0)
                pulse_div <= wdata;
            if (wr && addr == `VMC_ADDR_PARAM && gen_ok)
                gen_param <= wdata;
            // communication settings stay writable so a locked meter remains reachable
            if (wr && addr == `VMC_ADDR_COMM)
                comm_param <= wdata;
            if (wr && addr == `VMC_ADDR_PASSWORD)
                password_in <= wdata;
            if (wr && addr == `VMC_ADDR_ACC_SEL)
                acc_sel <= wdata[2:0];
            // sticky refusal flag; a new refusal beats a same-cycle clear
            if (gen_refuse || (sw_enter_req && !sw_enter))
                refused <= 1'b1;
            else if (w_cmd && wdata[`VMC_CMD_CLR_REFUSED])
                refused <= 1'b0;
        end
    end

    // ****************************************
    // inactivity countdown
    // ****************************************
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt  <= 32'h0;
            countdown <= `VMC_TIMEOUT_S_RST;
        end else begin
            // free-running tick: the first second after entry may be short
            tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
            if (!in_ver || any_button || verify_button)
                countdown <= timeout_s;
            else if (tick && countdown != 32'h0)
                countdown <= countdown - 32'h1;
        end
    end

    // ****************************************
    // display sequencer and pulse outputs
    // ****************************************
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scr_cnt     <= 32'h0;
            screen_sel  <= 2'h0;
            pulse_cnt   <= 32'h0;
            pulse_phase <= 1'b0;
            led_pulse   <= 2'h0;
            ir_pulse    <= 2'h0;
        end else begin
            // screens restart from the first one on every entry
            if (!in_ver) begin
                scr_cnt    <= 32'h0;
                screen_sel <= 2'h0;
            end else if (tick) begin
                if (scr_cnt == SCREEN_TICKS - 1) begin
                    scr_cnt    <= 32'h0;
                    if (screen_sel == `VMC_NUM_SCREENS - 1)
                        screen_sel <= 2'h0;
                    else
                        screen_sel <= screen_sel + 2'h1;
                end else begin
                    scr_cnt <= scr_cnt + 32'h1;
                end
            end
            // every pulse_div energy events toggle both pairs, so one output pulse takes twice pulse_div events
            if (!in_ver) begin
                pulse_cnt   <= 32'h0;
                // a stale phase would light the outputs at once on re-entry
                pulse_phase <= 1'b0;
            end else if (energy_pulse_event) begin
                if (pulse_cnt >= pulse_div - 32'h1) begin
                    pulse_cnt   <= 32'h0;
                    pulse_phase <= ~pulse_phase;
                end else begin
                    pulse_cnt <= pulse_cnt + 32'h1;
                end
            end
            led_pulse <= (in_ver && pulse_phase) ? 2'h3 : 2'h0;
            ir_pulse  <= (in_ver && pulse_phase) ? 2'h3 : 2'h0;
        end
    end

    // ****************************************
    // verification accumulators
    // ****************************************
    wire          acc_clr = exit_ver;
    wire          dem_clr = exit_ver || (in_ver && demand_reset_switch);
    wire [EW-1:0] acc_val [0:5];
    vmc_accum #(.WIDTH(EW)) u_real_del (.clk(clk), .rst_b(rst_n), .enable(in_ver),
        .clear(acc_clr), .increment(real_del_inc), .total(acc_val[0]));
    vmc_accum #(.WIDTH(EW)) u_real_rec (.clk(clk), .rst_b(rst_n), .enable(in_ver),
        .clear(acc_clr), .increment(real_rec_inc), .total(acc_val[1]));
    vmc_accum #(.WIDTH(EW)) u_react (.clk(clk), .rst_b(rst_n), .enable(in_ver),
        .clear(acc_clr), .increment(react_inc), .total(acc_val[2]));
    vmc_accum #(.WIDTH(EW)) u_appar (.clk(clk), .rst_b(rst_n), .enable(in_ver),
        .clear(acc_clr), .increment(appar_inc), .total(acc_val[3]));
    vmc_accum #(.WIDTH(EW)) u_dem_del (.clk(clk), .rst_b(rst_n), .enable(in_ver),
        .clear(dem_clr), .increment(demand_del_inc), .total(acc_val[4]));
    vmc_accum #(.WIDTH(EW)) u_dem_rec (.clk(clk), .rst_b(rst_n), .enable(in_ver),
        .clear(dem_clr), .increment(demand_rec_inc), .total(acc_val[5]));

    // ****************************************
    // mode outputs and read port
    // ****************************************
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            verify_active           <= 1'b0;
            regular_operation_state <= 1'b1;
            secondary_display_state <= 1'b0;
            billing_enable          <= 1'b1;
            remaining_s             <= 32'h0;
            rdata                   <= 32'h0;
        end else begin
            verify_active           <= in_ver;
            regular_operation_state <= (state == ST_REG);
            secondary_display_state <= (state == ST_ALT);
            billing_enable          <= !in_ver;
            remaining_s             <= in_ver ? countdown : 32'h0;
            rdata                   <= 32'h0;
            // command and password words read back as zero
            if (rd) begin
                case (addr)
                    `VMC_ADDR_CTRL:    rdata <= {30'h0, loss_enable, scaling_enable};
                    `VMC_ADDR_TIMEOUT: rdata <= timeout_s;
                    `VMC_ADDR_PULSE:   rdata <= pulse_div;
                    `VMC_ADDR_STATUS:  rdata <= {26'h0, screen_sel, refused,
                                             security_enabled, hw_locked, in_ver};
                    `VMC_ADDR_REMAIN:  rdata <= in_ver ? countdown : 32'h0;
                    `VMC_ADDR_COMM:    rdata <= comm_param;
                    `VMC_ADDR_PARAM:   rdata <= gen_param;
                    `VMC_ADDR_ACC_SEL: rdata <= {29'h0, acc_sel};
                    `VMC_ADDR_ACC_DATA:
                        rdata <= (acc_sel < 3'h6) ? acc_val[acc_sel] : 32'h0;
                    default:           rdata <= 32'h0;
                endcase
            end
        end
    end
endmodule

// ### test/testbench.sv
`timescale 1ns/1ns
`include "vmc_consts.vh"
module testbench;
    // ****
    // bench signals
    // ****
    reg         clk, rst_b, hw_locked, security_enabled, wr, rd, pulse_ev;
    reg  [3:0]  addr, req;
    reg  [31:0] wdata, real_inc, dem_inc, rv;
    reg  [7:0]  hold;
    wire [3:0]  btn;
    wire [31:0] rdata, remaining_s;
    wire        verify_active, regular_operation_state, secondary_display_state;
    wire        billing_enable, scaling_enable, loss_enable;
    wire [1:0]  screen_sel, led_pulse, ir_pulse;
    integer     err_total, tests_run, n;
    vmc_panel i_panel (.clk(clk), .req(req), .hold(hold), .btn(btn));
    // short tick keeps timeouts within a few hundred cycles
    vmc_top #(.TICK_CYCLES(20), .SCREEN_TICKS(1)) i_dut (
        .clk(clk), .rst_b(rst_b), .verify_button(btn[0]), .any_button(btn[1]),
        .demand_reset_switch(btn[2]), .alt_button(btn[3]), .hw_locked(hw_locked),
        .security_enabled(security_enabled), .real_del_inc(real_inc),
        .real_rec_inc(32'h0), .react_inc(32'h0), .appar_inc(32'h0),
        .demand_del_inc(dem_inc), .demand_rec_inc(32'h0), .energy_pulse_event(pulse_ev),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .verify_active(verify_active), .regular_operation_state(regular_operation_state),
        .secondary_display_state(secondary_display_state), .billing_enable(billing_enable),
        .scaling_enable(scaling_enable), .loss_enable(loss_enable), .screen_sel(screen_sel),
        .remaining_s(remaining_s), .led_pulse(led_pulse), .ir_pulse(ir_pulse));
    // ****
    // tasks
    // ****
    task step(input integer c);
        repeat (c) @(posedge clk);
    endtask
    task wr_reg(input [3:0] a, input [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input [3:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 rv = rdata;
    endtask
    task press(input integer b);
        @(posedge clk);
        req[b] <= 1'b1;
        @(posedge clk);
        req <= 4'h0;
    endtask
    task chk(input string nm, input [31:0] exp, input [31:0] got);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ****
    // scenarios
    // ****
    task t_reset;
        chk("regular", 32'h1, regular_operation_state);
        chk("scaling", 32'h0, scaling_enable);
        rd_reg(`VMC_ADDR_TIMEOUT);
        chk("timeout", `VMC_TIMEOUT_S_RST, rv);
        rd_reg(4'hF);
        chk("unmapped", 32'h0, rv);
    endtask
    task t_locked;
        wr_reg(`VMC_ADDR_CMD, 32'h1);
        step(3);
        chk("sw entry", 32'h0, verify_active);
        wr_reg(`VMC_ADDR_TIMEOUT, 32'h3);
        rd_reg(`VMC_ADDR_TIMEOUT);
        chk("locked timeout", `VMC_TIMEOUT_S_RST, rv);
        wr_reg(`VMC_ADDR_COMM, 32'h55);
        rd_reg(`VMC_ADDR_COMM);
        chk("comm", 32'h55, rv);
        wr_reg(`VMC_ADDR_PARAM, 32'h77);
        rd_reg(`VMC_ADDR_PARAM);
        chk("locked param", 32'h0, rv);
        rd_reg(`VMC_ADDR_STATUS);
        chk("refused", 32'h1, rv[`VMC_STAT_REFUSED]);
        wr_reg(`VMC_ADDR_CMD, 32'h8);
        rd_reg(`VMC_ADDR_STATUS);
        chk("refused clear", 32'h0, rv[`VMC_STAT_REFUSED]);
    endtask
    task t_verify;
        real_inc <= 32'h1;
        press(0);
        step(3);
        chk("button entry", 32'h1, verify_active);
        chk("billing", 32'h0, billing_enable);
        for (n = 0; n < 25 && screen_sel === 2'h0; n = n + 1) @(posedge clk);
        chk("screen one", 32'h1, screen_sel);
        for (n = 0; n < 25 && screen_sel === 2'h1; n = n + 1) @(posedge clk);
        chk("screen two", 32'h2, screen_sel);
        wr_reg(`VMC_ADDR_TIMEOUT, 32'h3);
        rd_reg(`VMC_ADDR_TIMEOUT);
        chk("timeout write", 32'h3, rv);
        wr_reg(`VMC_ADDR_CTRL, 32'h3);
        step(2);
        chk("scale on", 32'h1, scaling_enable);
        chk("loss on", 32'h1, loss_enable);
        chk("remain shown", 32'h1, remaining_s != 32'h0);
        wr_reg(`VMC_ADDR_PULSE, 32'h2);
        pulse_ev <= 1'b1;
        step(2);
        pulse_ev <= 1'b0;
        step(3);
        chk("pulses", 32'h3, led_pulse);
        wr_reg(`VMC_ADDR_ACC_SEL, 32'h0);
        rd_reg(`VMC_ADDR_ACC_DATA);
        chk("acc runs", 32'h1, rv != 32'h0);
        dem_inc <= 32'h1;
        step(4);
        dem_inc <= 32'h0;
        press(2);
        step(3);
        wr_reg(`VMC_ADDR_ACC_SEL, 32'h4);
        rd_reg(`VMC_ADDR_ACC_DATA);
        chk("demand clear", 32'h0, rv);
        wr_reg(`VMC_ADDR_CMD, 32'h2);
        step(3);
        chk("close", 32'h0, verify_active);
        wr_reg(`VMC_ADDR_ACC_SEL, 32'h0);
        rd_reg(`VMC_ADDR_ACC_DATA);
        chk("acc cleared", 32'h0, rv);
    endtask
    task t_timeout;
        hw_locked <= 1'b0;
        security_enabled <= 1'b1;
        wr_reg(`VMC_ADDR_CMD, 32'h1);
        step(3);
        chk("no password", 32'h0, verify_active);
        wr_reg(`VMC_ADDR_PASSWORD, 32'h1234_5678);
        wr_reg(`VMC_ADDR_CMD, 32'h1);
        step(30);
        hold <= 8'h3;
        press(1);
        // past the unreloaded deadline, short of the reloaded one
        step(35);
        chk("reload", 32'h1, verify_active);
        for (n = 0; n < 80 && verify_active !== 1'b0; n = n + 1) @(posedge clk);
        chk("expired", 32'h0, verify_active);
        chk("back regular", 32'h1, regular_operation_state);
        // one high cycle: every cycle of the alt button toggles the state
        hold <= 8'h1;
        press(3);
        step(3);
        chk("secondary", 32'h1, secondary_display_state);
        wr_reg(`VMC_ADDR_CMD, 32'h1);
        step(3);
        wr_reg(`VMC_ADDR_CMD, 32'h2);
        step(3);
        chk("from secondary", 32'h1, regular_operation_state);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        err_total = err_total + 1;
        print_verdict;
    end
    initial begin
        {rst_b, security_enabled, wr, rd, pulse_ev} = 5'h0;
        hw_locked = 1'b1;
        {addr, req, wdata, real_inc, dem_inc} = 0;
        hold = 8'h1;
        err_total = 0;
        tests_run = 0;
        step(2);
        rst_b <= 1'b1;
        step(3);
        t_reset;
        t_locked;
        t_verify;
        t_timeout;
        print_verdict;
    end
endmodule
bind vmc_top vmc_props i_props (.clk(clk), .rst_b(rst_b), .verify_button(verify_button),
    .any_button(any_button), .rd(rd), .rdata(rdata), .verify_active(verify_active),
    .regular_operation_state(regular_operation_state),
    .secondary_display_state(secondary_display_state), .billing_enable(billing_enable),
    .screen_sel(screen_sel), .remaining_s(remaining_s), .led_pulse(led_pulse),
    .ir_pulse(ir_pulse));

// ### test/vmc_panel.sv
`timescale 1ns/1ns
// ****
// front panel model
// ****
// a request pulse becomes a press held for hold cycles
module vmc_panel (
    // clock
    input  wire       clk,
    // requests
    input  wire [3:0] req,
    input  wire [7:0] hold,
    // verify, any, demand reset, alt
    output reg  [3:0] btn
);
    reg [7:0] cnt [0:3];
    integer   j;
    initial btn = 4'h0;
    always @(posedge clk) begin
        for (j = 0; j < 4; j = j + 1) begin
            if (req[j]) begin
                cnt[j] <= hold;
                btn[j] <= 1'b1;
            end else if (cnt[j] > 8'h1) begin
                cnt[j] <= cnt[j] - 8'h1;
            end else begin
                cnt[j] <= 8'h0;
                btn[j] <= 1'b0;
            end
        end
    end
endmodule

// ### test/vmc_top_properties.sv
`timescale 1ns/1ns
module vmc_props (
    // clock and reset
    input wire        clk,
    input wire        rst_b,
    // watched inputs
    input wire        verify_button,
    input wire        any_button,
    input wire        rd,
    // watched outputs
    input wire [31:0] rdata,
    input wire        verify_active,
    input wire        regular_operation_state,
    input wire        secondary_display_state,
    input wire        billing_enable,
    input wire [1:0]  screen_sel,
    input wire [31:0] remaining_s,
    input wire [1:0]  led_pulse,
    input wire [1:0]  ir_pulse
);
    // ****
    // properties
    // ****
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_press;
        verify_button && !verify_active;
    endsequence
    sequence s_entered;
        ##2 verify_active;
    endsequence
    property p_enter;
        s_press |-> s_entered;
    endproperty
    property p_quiet;
        !verify_active |-> remaining_s == 32'h0 && screen_sel == 2'h0;
    endproperty
    property p_billing;
        verify_active |-> !billing_enable;
    endproperty
    property p_pulse_off;
        !verify_active |-> led_pulse == 2'h0 && ir_pulse == 2'h0;
    endproperty
    property p_pulse_pair;
        led_pulse == ir_pulse && led_pulse[0] == led_pulse[1];
    endproperty
    property p_exit;
        $fell(verify_active) |-> regular_operation_state && !secondary_display_state;
    endproperty
    // a press reloads the count, so only quiet stretches must step by one
    property p_step;
        verify_active && $past(verify_active) && !$past(any_button)
            && !$past(any_button, 2) && $changed(remaining_s)
            |-> remaining_s == $past(remaining_s) - 32'h1;
    endproperty
    property p_rdata;
        !$past(rd) |-> rdata == 32'h0;
    endproperty
    property p_screen;
        verify_active && $past(verify_active) && $changed(screen_sel)
            |-> screen_sel == $past(screen_sel) + 2'h1;
    endproperty
    a_enter: assert property (p_enter) else $error("button did not enter");
    a_quiet: assert property (p_quiet) else $error("idle outputs not zero");
    a_billing: assert property (p_billing) else $error("billing ran");
    a_pulse_off: assert property (p_pulse_off) else $error("pulses outside");
    a_pulse_pair: assert property (p_pulse_pair) else $error("pulse pairs differ");
    a_exit: assert property (p_exit) else $error("exit not regular");
    a_step: assert property (p_step) else $error("countdown step wrong");
    a_rdata: assert property (p_rdata) else $error("read data without read");
    a_screen: assert property (p_screen) else $error("screen order wrong");
endmodule
